// file: core/dcf_host.sv
// Purpose: Host end receiving the bottom fault line.
// Assumes: Line level synchronous to sys_clk_in.
// Notes:   Filters as a unit does; pulse mode set by host.
`default_nettype none
module dcf_host
    import dcf_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    dcf_if.lower             up,
    input  wire logic        pulse_mode_in,
    input  wire logic [2:0]  pulse_period_select_in,
    input  wire logic        clear_in,
    output logic             static_fault_out,
    output logic             loss_fault_out,
    output logic             fault_irq_out
);
    typedef struct packed {
        logic [CNT_W-1:0] hi_cnt;
        logic [CNT_W-1:0] lo_cnt;
        logic             stat;
        logic             loss;
        logic             irq;
    } dcf_host_st_t;

    dcf_host_st_t r, nxt;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] hi_lim;
    logic [CNT_W-1:0] lo_lim;

    // -------------------------------------------------------------
    // Filters
    // -------------------------------------------------------------
    always_comb begin
        case (pulse_period_select_in)
            SEL_8MS:   period = CNT_W'(PERIOD1_CYC);
            SEL_32MS:  period = CNT_W'(PERIOD2_CYC);
            SEL_128MS: period = CNT_W'(PERIOD3_CYC);
            default:   period = CNT_W'(PERIOD0_CYC);
        endcase
        hi_lim = pulse_mode_in ? CNT_W'(LONG_FILTER_CYC)
                               : CNT_W'(SHORT_FILTER_CYC);
        lo_lim = CNT_W'((32'(period) * LOSS_NUM) / LOSS_DEN);
        nxt = r;
        if (!up.line) begin
            nxt.hi_cnt = '0;
        end else if (r.hi_cnt < hi_lim) begin
            nxt.hi_cnt = r.hi_cnt + 1'b1;
        end
        if (!pulse_mode_in || up.line) begin
            nxt.lo_cnt = '0;
        end else if (r.lo_cnt < lo_lim) begin
            nxt.lo_cnt = r.lo_cnt + 1'b1;
        end
        if (clear_in) begin
            nxt.stat = 1'b0;
            nxt.loss = 1'b0;
        end
        if (r.hi_cnt >= hi_lim) begin
            nxt.stat = 1'b1;
        end
        if (pulse_mode_in && r.lo_cnt >= lo_lim) begin
            nxt.loss = 1'b1;
        end
        nxt.irq = nxt.stat || nxt.loss;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign static_fault_out = r.stat;
    assign loss_fault_out   = r.loss;
    assign fault_irq_out    = r.irq;
endmodule // dcf_host
`default_nettype wire

// file: core/dcf_if.sv
// Purpose: One-way fault wire from an upper unit to a lower party.
// Assumes: Single push-pull line, no enable needed.
// Notes:   Upper end drives line, lower end reads it.
`default_nettype none
interface dcf_if;
    logic line;
    modport upper (output line);
    modport lower (input line);
endinterface
`default_nettype wire

// file: core/dcf_pkg.sv
// Purpose: Shared constants and types for the daisy chain fault line.
// Assumes: 40 MHz system clock on both ends.
// Notes:   Times are in microseconds; cycle counts derive from them.
`default_nettype none
package dcf_pkg;
    localparam int CLK_MHZ            = 40;
    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int PULSE_WIDTH_US     = 500;
    localparam int SHORT_FILTER_US    = 300;
    localparam int LONG_FILTER_US     = 3500;
    localparam int PERIOD0_US         = 4000;
    localparam int PERIOD1_US         = 8000;
    localparam int PERIOD2_US         = 32000;
    localparam int PERIOD3_US         = 128000;
    localparam int PULSE_WIDTH_CYC    = PULSE_WIDTH_US * CLK_MHZ;
    localparam int SHORT_FILTER_CYC   = SHORT_FILTER_US * CLK_MHZ;
    localparam int LONG_FILTER_CYC    = LONG_FILTER_US * CLK_MHZ;
    localparam int PERIOD0_CYC        = PERIOD0_US * CLK_MHZ;
    localparam int PERIOD1_CYC        = PERIOD1_US * CLK_MHZ;
    localparam int PERIOD2_CYC        = PERIOD2_US * CLK_MHZ;
    localparam int PERIOD3_CYC        = PERIOD3_US * CLK_MHZ;
    // Loss limit is 1.2 times the period
    localparam int LOSS_NUM           = 12;
    localparam int LOSS_DEN           = 10;
    localparam int CNT_W              = 24;
    // -------------------------------------------------------------
    // Period select codes and status word
    // -------------------------------------------------------------
    localparam logic [2:0] SEL_4MS    = 3'h0;
    localparam logic [2:0] SEL_8MS    = 3'h1;
    localparam logic [2:0] SEL_32MS   = 3'h2;
    localparam logic [2:0] SEL_128MS  = 3'h3;
    localparam int GSW_FAULT_BIT      = 25;
    localparam logic [2:0] SEL_RESET  = 3'h0;

    typedef enum logic [1:0] {
        DCF_NORMAL  = 2'b00,
        DCF_CYCLIC  = 2'b01,
        DCF_SILENT  = 2'b11,
        DCF_SLEEP   = 2'b10
    } dcf_pstate_t;
endpackage
`default_nettype wire

// file: core/dcf_unit.sv
// Purpose: Fault line logic of one stacked monitor unit.
// Assumes: Upstream level on fault_in_in is synchronous to sys_clk_in.
// Notes:   Internal failure sources and the serial frame are outside.
`default_nettype none
// Operation
// - Works in normal, cyclic, silent, sleep states
// - Detected fault moves low power to normal
// - Fault drives output active, else inactive
// - Inactive low or pulse train, active high
// - Fault keeps output asserted and normal
// - Host clears latched faults before release
// - Cleared faults return output to inactive
// - Pulse period selectable, pulse width fixed
// - Force bit raises output on top unit
// - Host disables pulses before low power
// - Sense upstream only when enabled, not top
// - Host sets top unit receiver off
// - Long high with pulses flags static fault
// - Low over 1.2 periods flags pulse loss
// - Short high without pulses flags static fault
// - Disabled receiver sees input as low
// - Top unit ignores receiver enable
// - Lower unit propagates upstream fault downward
// - Host filters like the units
// - Host finds failing unit by status bit
// - Codes select 4, 8, 32, 128 ms
// - Status bit 25 shows internal failure; here bit 1 of global_status_word_out
module dcf_unit
    import dcf_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    dcf_if.upper             down,
    input  wire logic        fault_in_in,
    input  wire logic        internal_fault_in,
    input  wire logic        cyclic_on_phase_in,
    input  wire logic [1:0]  power_state_in,
    input  wire logic        comm_timeout_in,
    input  wire logic        pulse_train_enable_in,
    input  wire logic [2:0]  pulse_period_select_in,
    input  wire logic        fault_out_force_in,
    input  wire logic        fault_in_enable_in,
    input  wire logic        top_of_chain_in,
    input  wire logic        clear_faults_in,
    output logic             fault_out_out,
    output logic             upstream_static_fault_out,
    output logic             pulse_loss_fault_out,
    output logic             internal_fault_out,
    output logic             wake_to_normal_out,
    output logic [1:0]       global_status_word_out
);
    typedef struct packed {
        logic [CNT_W-1:0] per_cnt;
        logic [CNT_W-1:0] hi_cnt;
        logic [CNT_W-1:0] lo_cnt;
        logic             prev_in;
        logic             line;
        logic             stat_flt;
        logic             loss_flt;
        logic             int_flt;
        logic             wake;
        logic             roll;
    } dcf_unit_st_t;

    dcf_unit_st_t r, nxt;
    dcf_pstate_t  pst;
    logic         sensed;
    logic         rx_on;
    logic         normal;
    logic         hb_on;
    logic         self_ok;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] hi_lim;
    logic [CNT_W-1:0] lo_lim;

    // -------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------
    // Longest spans must fit the shared counter width
    if (PERIOD3_CYC * LOSS_NUM / LOSS_DEN >= (1 << CNT_W)
        || LONG_FILTER_CYC >= (1 << CNT_W)) begin : g_cnt_chk
        $error("Counter width too small for filter spans");
    end

    // -------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------
    always_comb begin
        pst    = dcf_pstate_t'(power_state_in);
        normal = (pst == DCF_NORMAL);
        hb_on  = normal && pulse_train_enable_in;
        case (pulse_period_select_in)
            SEL_4MS:   period = CNT_W'(PERIOD0_CYC);
            SEL_8MS:   period = CNT_W'(PERIOD1_CYC);
            SEL_32MS:  period = CNT_W'(PERIOD2_CYC);
            SEL_128MS: period = CNT_W'(PERIOD3_CYC);
            default:   period = CNT_W'(PERIOD0_CYC);
        endcase
        // Long span rides over the heartbeat pulses
        // long filter with pulses
        hi_lim = hb_on ? CNT_W'(LONG_FILTER_CYC)
                       : CNT_W'(SHORT_FILTER_CYC);
        lo_lim = CNT_W'((32'(period) * LOSS_NUM) / LOSS_DEN);
        rx_on  = fault_in_enable_in && !top_of_chain_in;
        sensed = fault_in_in && rx_on;
        // self detect only in on phase when cyclic
        self_ok = (pst == DCF_NORMAL) || (pst == DCF_CYCLIC
                  && cyclic_on_phase_in);
    end

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        nxt = r;
        nxt.prev_in = sensed;
        nxt.roll = ~r.roll;
        if (!hb_on || r.per_cnt >= period - 1'b1) begin
            nxt.per_cnt = '0;
        end else begin
            nxt.per_cnt = r.per_cnt + 1'b1;
        end
        if (!sensed) begin
            nxt.hi_cnt = '0;
        end else if (r.hi_cnt < hi_lim) begin
            nxt.hi_cnt = r.hi_cnt + 1'b1;
        end
        // No receiver means no upstream heartbeat to miss
        // loss timer held clear while input high
        if (!hb_on || !rx_on || (sensed && !r.prev_in) || sensed) begin
            nxt.lo_cnt = '0;
        end else if (r.lo_cnt < lo_lim) begin
            nxt.lo_cnt = r.lo_cnt + 1'b1;
        end
        // Clear first so a same-cycle event still latches
        // host clear, set wins
        if (clear_faults_in) begin
            nxt.stat_flt = 1'b0;
            nxt.loss_flt = 1'b0;
            nxt.int_flt  = 1'b0;
        end
        if (r.hi_cnt >= hi_lim) begin
            nxt.stat_flt = 1'b1;
        end
        if (hb_on && r.lo_cnt >= lo_lim) begin
            nxt.loss_flt = 1'b1;
        end
        if (internal_fault_in && self_ok) begin
            nxt.int_flt = 1'b1;
        end
        if (comm_timeout_in) begin
            nxt.wake = 1'b0;
        end else if (nxt.stat_flt || (pst == DCF_CYCLIC && nxt.int_flt)
                     || (normal && (r.stat_flt || r.loss_flt
                     || r.int_flt))) begin
            nxt.wake = 1'b1;
        end
        if (normal && (r.stat_flt || r.loss_flt || r.int_flt
            || (fault_out_force_in && top_of_chain_in))) begin
            nxt.line = 1'b1;
        end else begin
            nxt.line = hb_on && (r.per_cnt < CNT_W'(PULSE_WIDTH_CYC));
        end
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign down.line                  = r.line;
    assign fault_out_out              = r.line;
    assign upstream_static_fault_out  = r.stat_flt;
    assign pulse_loss_fault_out       = r.loss_flt;
    assign internal_fault_out         = r.int_flt;
    assign wake_to_normal_out         = r.wake;
    assign global_status_word_out     = {r.int_flt, r.roll};
endmodule // dcf_unit
`default_nettype wire

// file: verification/daisy_chain_fault_line_test.sv
// Purpose: Self-checking bench joining one unit to the host
// Assumes: Select 000 keeps heartbeat spans short
// Notes:   Long filter and loss spans are checked neither here nor in dcf_chk
`default_nettype none
module daisy_chain_fault_line_test
    import dcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       f_in = 1'b0;
    logic       int_f = 1'b0;
    logic       pte = 1'b1;
    logic       en = 1'b0;
    logic       frc = 1'b0;
    logic       top = 1'b0;
    logic       clr = 1'b0;
    logic       hclr = 1'b0;
    logic       cop = 1'b1;
    logic       ct = 1'b0;
    logic [1:0] pst = DCF_NORMAL;
    logic       us_f, pl_f, in_f, wake, fo, h_st, h_ls, h_irq;
    logic [1:0] global_status_word;
    int         error_cnt = 0;
    int         n_tests = 0;
    always #12.5 clk = ~clk;
    dcf_if dcf_if_i ();
    dcf_unit dcf_unit_i (.sys_clk_in(clk), .rstn_in(rstn), .down(dcf_if_i),
        .fault_in_in(f_in), .internal_fault_in(int_f),
        .cyclic_on_phase_in(cop), .power_state_in(pst),
        .comm_timeout_in(ct), .pulse_train_enable_in(pte),
        .pulse_period_select_in(SEL_4MS), .fault_out_force_in(frc),
        .fault_in_enable_in(en), .top_of_chain_in(top),
        .clear_faults_in(clr), .fault_out_out(fo),
        .upstream_static_fault_out(us_f), .pulse_loss_fault_out(pl_f),
        .internal_fault_out(in_f), .wake_to_normal_out(wake),
        .global_status_word_out(global_status_word));
    dcf_host dcf_host_i (.sys_clk_in(clk), .rstn_in(rstn), .up(dcf_if_i),
        .pulse_mode_in(pte), .pulse_period_select_in(SEL_4MS),
        .clear_in(hclr), .static_fault_out(h_st), .loss_fault_out(h_ls),
        .fault_irq_out(h_irq));
    dcf_chk dcf_chk_i (.sys_clk_in(clk), .rstn_in(rstn),
        .line(dcf_if_i.line), .fault_in_in(f_in), .power_state_in(pst),
        .internal_fault_in(int_f),
        .pulse_train_enable_in(pte), .fault_out_force_in(frc),
        .fault_in_enable_in(en), .top_of_chain_in(top),
        .clear_faults_in(clr), .fault_out_out(fo),
        .upstream_static_fault_out(us_f), .pulse_loss_fault_out(pl_f),
        .internal_fault_out(in_f), .wake_to_normal_out(wake),
        .global_status_word_out(global_status_word));
    task automatic chk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Unit clear first, host later, so the host never sees a late high
    task automatic t_clear;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        cyc(4);
        hclr <= 1'b1;
        @(posedge clk);
        hclr <= 1'b0;
        cyc(3);
        @(negedge clk);
    endtask
    task automatic t_pulse;
        int w;
        w = 0;
        repeat (2000) if (fo !== 1'b1) @(negedge clk);
        while (fo === 1'b1 && w < 30000) begin
            w++;
            @(negedge clk);
        end
        chk(w == PULSE_WIDTH_CYC, 1'b1);
        cyc(1000);
        @(negedge clk);
        chk(fo, 1'b0);
        chk(h_st | h_ls, 1'b0);
        chk(pl_f, 1'b0);
        @(posedge clk);
        pte <= 1'b0;
        en <= 1'b1;
    endtask
    task automatic t_reject;
        @(posedge clk);
        f_in <= 1'b1;
        cyc(SHORT_FILTER_CYC - 100);
        f_in <= 1'b0;
        cyc(10);
        @(negedge clk);
        chk(us_f, 1'b0);
        chk(fo, 1'b0);
    endtask
    task automatic t_sleep;
        @(posedge clk);
        pst <= DCF_SLEEP;
        f_in <= 1'b1;
        cyc(SHORT_FILTER_CYC + 10);
        @(negedge clk);
        chk(us_f, 1'b1);
        chk(wake, 1'b1);
        chk(fo, 1'b0);
        @(posedge clk);
        pst <= DCF_NORMAL;
        f_in <= 1'b0;
        cyc(SHORT_FILTER_CYC + 10);
        @(negedge clk);
        chk(fo, 1'b1);
        chk(h_irq & h_st, 1'b1);
        t_clear();
        chk(us_f | fo | h_st, 1'b0);
    endtask
    task automatic t_gate(input logic e, input logic t);
        @(posedge clk);
        en <= e;
        top <= t;
        @(posedge clk);
        f_in <= 1'b1;
        cyc(SHORT_FILTER_CYC + 50);
        f_in <= 1'b0;
        @(negedge clk);
        chk(us_f | fo, 1'b0);
    endtask
    task automatic t_force_int;
        @(posedge clk);
        frc <= 1'b1;
        en <= 1'b0;
        top <= 1'b1;
        cyc(3);
        @(negedge clk);
        chk(fo, 1'b1);
        @(posedge clk);
        frc <= 1'b0;
        int_f <= 1'b1;
        @(posedge clk);
        int_f <= 1'b0;
        cyc(4);
        @(negedge clk);
        chk(in_f & global_status_word[1] & fo, 1'b1);
        t_clear();
        chk(in_f | fo, 1'b0);
    endtask
    // Timeout drops the wake request, then self detect waits for on phase
    task automatic t_cyclic;
        @(posedge clk);
        ct <= 1'b1;
        @(posedge clk);
        ct <= 1'b0;
        pst <= DCF_CYCLIC;
        cop <= 1'b0;
        int_f <= 1'b1;
        cyc(3);
        @(negedge clk);
        chk(wake, 1'b0);
        chk(in_f | fo, 1'b0);
        @(posedge clk);
        cop <= 1'b1;
        cyc(3);
        @(negedge clk);
        chk(in_f & wake, 1'b1);
        chk(fo, 1'b0);
        @(posedge clk);
        pst <= DCF_NORMAL;
        int_f <= 1'b0;
        cyc(3);
        @(negedge clk);
        chk(fo, 1'b1);
        t_clear();
        chk(in_f | fo, 1'b0);
    endtask
    initial begin
        cyc(10);
        rstn <= 1'b1;
        @(negedge clk);
        t_pulse();
        t_reject();
        t_sleep();
        t_gate(1'b0, 1'b0);
        t_gate(1'b1, 1'b1);
        t_force_int();
        t_cyclic();
        results();
    end
    initial begin
        cyc(95000);
        error_cnt++;
        results();
    end
endmodule // daisy_chain_fault_line_test
`default_nettype wire

// file: verification/dcf_chk.sv
// Purpose: Assertions on the fault line between unit and host
// Assumes: One clock, synchronous active low reset
// Notes:   Counters stand in for long repetitions
`default_nettype none
module dcf_chk
    import dcf_pkg::*;
(
    input wire logic       sys_clk_in,
    input wire logic       rstn_in,
    input wire logic       line,
    input wire logic       fault_in_in,
    input wire logic       internal_fault_in,
    input wire logic [1:0] power_state_in,
    input wire logic       pulse_train_enable_in,
    input wire logic       fault_out_force_in,
    input wire logic       fault_in_enable_in,
    input wire logic       top_of_chain_in,
    input wire logic       clear_faults_in,
    input wire logic       fault_out_out,
    input wire logic       upstream_static_fault_out,
    input wire logic       pulse_loss_fault_out,
    input wire logic       internal_fault_out,
    input wire logic       wake_to_normal_out,
    input wire logic [1:0] global_status_word_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // ------------------------------------------
    // Run counters
    // ------------------------------------------
    logic [23:0] hi_r;
    logic [23:0] run_r;
    logic        sense;
    logic        any_f;
    assign sense = fault_in_enable_in && !top_of_chain_in
                   && !pulse_train_enable_in;
    assign any_f = upstream_static_fault_out | pulse_loss_fault_out
                   | internal_fault_out;
    always_ff @(posedge sys_clk_in) begin
        hi_r  <= (rstn_in && fault_in_in && sense) ? hi_r + 24'h1 : 24'h0;
        run_r <= (rstn_in && line) ? run_r + 24'h1 : 24'h0;
    end
    sequence s_normal2;
        (power_state_in == DCF_NORMAL) [*2];
    endsequence
    sequence s_lowpow2;
        (power_state_in != DCF_NORMAL) [*2];
    endsequence
    a_idle_low: assert property (s_normal2 ##0 (!any_f
        && !pulse_train_enable_in && !fault_out_force_in)
        |=> !line && !fault_out_out)
        else $error("line high with no failure");
    a_lowpow_quiet: assert property (s_lowpow2 |-> !line)
        else $error("line high in low power");
    a_fault_drives: assert property (s_normal2 ##0 any_f |=> line)
        else $error("latched fault not on line");
    a_latch_holds: assert property (upstream_static_fault_out
        && !clear_faults_in |=> upstream_static_fault_out)
        else $error("static flag dropped without clear");
    a_rx_gated: assert property ($rose(upstream_static_fault_out)
        |-> $past(fault_in_enable_in) && !$past(top_of_chain_in))
        else $error("static flag with receiver off");
    a_filter_min: assert property ($rose(upstream_static_fault_out)
        && !pulse_train_enable_in |-> hi_r >= SHORT_FILTER_CYC)
        else $error("static flag before short filter");
    a_filter_max: assert property (hi_r == SHORT_FILTER_CYC + 4
        |-> upstream_static_fault_out)
        else $error("static flag late");
    a_force_top: assert property (s_normal2 ##0
        (fault_out_force_in && top_of_chain_in) |=> line)
        else $error("force did not raise line");
    a_wake_sleep: assert property ($rose(upstream_static_fault_out)
        && power_state_in != DCF_NORMAL |-> ##[0:2] wake_to_normal_out)
        else $error("no wake request");
    a_status_bit: assert property (s_normal2 ##0 internal_fault_in
        |=> global_status_word_out[1] && internal_fault_out)
        else $error("status bit not set by internal failure");
    a_pulse_width: assert property ($fell(line)
        && $past(pulse_train_enable_in) && !$past(any_f)
        && !$past(fault_out_force_in) |-> run_r == PULSE_WIDTH_CYC)
        else $error("pulse width wrong");
endmodule // dcf_chk
`default_nettype wire
